// ### verilog/stall_cfg_pkg.sv
package stall_cfg_pkg;
    localparam logic [7:0] ADDR_FAULT_PROTECT = 8'h06;
    localparam logic [7:0] ADDR_STALL_CONTROL = 8'h07;
    localparam logic [7:0] ADDR_STALL_THRESHOLD = 8'h08;
    localparam int FAULT_CLEAR_BIT = 7;
    localparam int LOCK_LSB = 4;
    localparam int OPEN_LOAD_EN_BIT = 3;
    localparam int OVERCURRENT_BIT = 2;
    localparam int OVERHEAT_BIT = 1;
    localparam int TEMP_REPORT_BIT = 0;
    localparam int STALL_LEARN_BIT = 5;
    localparam int STALL_ENABLE_BIT = 4;
    localparam int STALL_REPORT_BIT = 3;
    localparam int OPEN_LOAD_TIME_SELECT_LSB = 1;
    localparam int BLANK_SEL_BIT = 0;
    localparam logic [2:0] LOCK_CODE = 3'h6;
    localparam logic [2:0] UNLOCK_CODE = 3'h3;
    localparam logic [7:0] FAULT_PROTECT_RESET = 8'h30;
    localparam logic [7:0] STALL_CONTROL_RESET = 8'h08;
    localparam logic [7:0] STALL_THRESHOLD_RESET = 8'h0F;
    localparam int CLK_NS = 8;
    localparam int BLANK_FIXED_NS = 500;
    localparam int BLANK_FIXED_CYCLES = (BLANK_FIXED_NS + CLK_NS - 1) / CLK_NS;
    localparam int OL_TIME0_MS = 200;
    localparam int OL_TIME1_MS = 125;
    localparam int OL_TIME2_MS = 75;
    localparam int OL_TIME3_MS = 3;
    localparam longint CYC_PER_MS = 1000000 / CLK_NS;
    localparam int OL_CYCLES0 = int'(OL_TIME0_MS * CYC_PER_MS);
    localparam int OL_CYCLES1 = int'(OL_TIME1_MS * CYC_PER_MS);
    localparam int OL_CYCLES2 = int'(OL_TIME2_MS * CYC_PER_MS);
    localparam int OL_CYCLES3 = int'(OL_TIME3_MS * CYC_PER_MS);
    localparam int LEARN_CYCLES = 64;
endpackage

// ### verilog/fault_latch.sv
`timescale 1ns/1ns
module fault_latch (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Control
    input wire logic i_condition,
    input wire logic i_auto_mode,
    input wire logic i_clear,
    // Status
    output logic o_fault
);
    logic fault_reg;
    logic fault_next;
    // Set beats clear; auto mode follows the condition
    assign fault_next = i_condition | (~i_auto_mode & fault_reg & ~i_clear);
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            fault_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
        end
    end
    assign o_fault = fault_reg;
endmodule // fault_latch

// ### verilog/stall_fault_regs.sv
`timescale 1ns/1ns
module stall_fault_regs #(
    parameter bit TIMED_VARIANT = 1'b1,
    parameter int OL_CYCLES_0 = stall_cfg_pkg::OL_CYCLES0,
    parameter int OL_CYCLES_1 = stall_cfg_pkg::OL_CYCLES1,
    parameter int OL_CYCLES_2 = stall_cfg_pkg::OL_CYCLES2,
    parameter int OL_CYCLES_3 = stall_cfg_pkg::OL_CYCLES3,
    parameter int LEARN_CYCLES = stall_cfg_pkg::LEARN_CYCLES
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // Register port from serial decoder
    input wire logic i_wr_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    output logic [7:0] o_rd_data,
    // Protection conditions, same clock domain
    input wire logic i_overcurrent,
    input wire logic i_overheat,
    input wire logic i_temp_warning,
    input wire logic i_open_load_raw,
    input wire logic i_stall_raw,
    input wire logic i_slew_blank_done,
    input wire logic i_stall_learn_done,
    // Status and settings
    output logic o_fault_out_n,
    output logic o_locked,
    output logic o_overcurrent_fault,
    output logic o_overheat_fault,
    output logic o_open_load_fault,
    output logic o_stall_fault,
    output logic o_blank_done,
    output logic [7:0] o_stall_threshold_count
);
    logic [7:0] fault_protect_reg;
    logic [7:0] stall_control_reg;
    logic [7:0] stall_threshold_reg;
    logic [7:0] fault_protect_next;
    logic [7:0] stall_control_next;
    logic [31:0] ol_count_reg;
    logic [31:0] ol_limit;
    logic [31:0] learn_count_reg;
    logic [7:0] blank_count_reg;
    logic [7:0] rd_data_reg;
    logic fault_clear_reg;
    logic [2:0] lock_field;
    logic locked;
    logic hit_fp;
    logic hit_sc;
    logic hit_th;
    logic wr_fp;
    logic wr_sc;
    logic wr_th;
    logic lock_wr;
    logic [2:0] lock_next;
    logic learn_busy;
    logic learn_done;
    logic clr;
    logic ol_seen;
    logic stall_seen;
    logic [1:0] ol_sel;
    logic blank_fixed_done;

    assign lock_field = fault_protect_reg[stall_cfg_pkg::LOCK_LSB +: 3];
    assign locked = (lock_field == stall_cfg_pkg::LOCK_CODE);
    assign hit_fp = (i_addr == stall_cfg_pkg::ADDR_FAULT_PROTECT);
    assign hit_sc = (i_addr == stall_cfg_pkg::ADDR_STALL_CONTROL);
    assign hit_th = (i_addr == stall_cfg_pkg::ADDR_STALL_THRESHOLD);
    // Locked writes to stall control and threshold are silently dropped, no error flag
    assign wr_fp = i_wr_en & hit_fp;
    assign wr_sc = i_wr_en & hit_sc & ~locked;
    assign wr_th = i_wr_en & hit_th & ~locked;
    assign lock_wr = wr_fp & (locked
        ? (i_wr_data[stall_cfg_pkg::LOCK_LSB +: 3] == stall_cfg_pkg::UNLOCK_CODE)
        : (i_wr_data[stall_cfg_pkg::LOCK_LSB +: 3] == stall_cfg_pkg::LOCK_CODE));
    assign lock_next = lock_wr ? i_wr_data[stall_cfg_pkg::LOCK_LSB +: 3] : lock_field;
    // Low settings of fault_protect are frozen while locked
    assign fault_protect_next = {1'b0, lock_next,
        (wr_fp & ~locked) ? i_wr_data[3:0] : fault_protect_reg[3:0]};
    assign learn_done = learn_busy & ((learn_count_reg == 32'(LEARN_CYCLES - 1))
        | i_stall_learn_done);
    // Reserved bits kept at zero; timing bits only exist on the timed variant
    assign stall_control_next = wr_sc
        ? {2'h0, i_wr_data[5:3], TIMED_VARIANT ? i_wr_data[2:0] : 3'h0}
        : {2'h0, stall_control_reg[5] & ~learn_done, stall_control_reg[4:0]};
    assign learn_busy = stall_control_reg[stall_cfg_pkg::STALL_LEARN_BIT];
    // Fault clear is a one-cycle pulse out of the register
    assign clr = fault_clear_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            fault_protect_reg <= stall_cfg_pkg::FAULT_PROTECT_RESET;
            stall_control_reg <= stall_cfg_pkg::STALL_CONTROL_RESET;
            stall_threshold_reg <= stall_cfg_pkg::STALL_THRESHOLD_RESET;
            fault_clear_reg <= 1'b0;
        end else begin
            fault_protect_reg <= fault_protect_next;
            stall_control_reg <= stall_control_next;
            if (wr_th) begin
                stall_threshold_reg <= i_wr_data;
            end
            fault_clear_reg <= wr_fp & i_wr_data[stall_cfg_pkg::FAULT_CLEAR_BIT];
        end
    end

    // Stall learning timer
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !learn_busy) begin
            learn_count_reg <= 32'h0;
        end else begin
            learn_count_reg <= learn_count_reg + 32'h1;
        end
    end

    // Open-load detection window
    assign ol_sel = TIMED_VARIANT ? stall_control_reg[stall_cfg_pkg::OPEN_LOAD_TIME_SELECT_LSB +: 2] : 2'h0;
    assign ol_limit = (ol_sel == 2'h0) ? 32'(OL_CYCLES_0)
        : (ol_sel == 2'h1) ? 32'(OL_CYCLES_1)
        : (ol_sel == 2'h2) ? 32'(OL_CYCLES_2) : 32'(OL_CYCLES_3);
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || !i_open_load_raw
                || !fault_protect_reg[stall_cfg_pkg::OPEN_LOAD_EN_BIT]) begin
            ol_count_reg <= 32'h0;
        end else if (ol_count_reg < ol_limit) begin
            ol_count_reg <= ol_count_reg + 32'h1;
        end
    end
    // Detection is asserted at the end of the window, a worst-case bound
    assign ol_seen = fault_protect_reg[stall_cfg_pkg::OPEN_LOAD_EN_BIT]
        & (ol_count_reg >= ol_limit - 32'h1) & i_open_load_raw;

    // Blanking after slow decay
    always_ff @(posedge i_ref_clk) begin
        // Counts once from reset; no per-decay restart in this block
        if (i_reset) begin
            blank_count_reg <= 8'h0;
        end else if (blank_count_reg < 8'(stall_cfg_pkg::BLANK_FIXED_CYCLES)) begin
            blank_count_reg <= blank_count_reg + 8'h1;
        end
    end
    assign blank_fixed_done = (blank_count_reg == 8'(stall_cfg_pkg::BLANK_FIXED_CYCLES));
    assign o_blank_done = (TIMED_VARIANT && stall_control_reg[stall_cfg_pkg::BLANK_SEL_BIT])
        ? i_slew_blank_done : blank_fixed_done;

    assign stall_seen = stall_control_reg[stall_cfg_pkg::STALL_ENABLE_BIT] & i_stall_raw;

    fault_latch u_ocp (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_condition(i_overcurrent),
        .i_auto_mode(fault_protect_reg[stall_cfg_pkg::OVERCURRENT_BIT]),
        .i_clear(clr),
        .o_fault(o_overcurrent_fault)
    );
    fault_latch u_otsd (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_condition(i_overheat),
        .i_auto_mode(fault_protect_reg[stall_cfg_pkg::OVERHEAT_BIT]),
        .i_clear(clr),
        .o_fault(o_overheat_fault)
    );
    fault_latch u_ol (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_condition(ol_seen),
        .i_auto_mode(1'b0),
        .i_clear(clr),
        .o_fault(o_open_load_fault)
    );
    fault_latch u_stall (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_condition(stall_seen),
        .i_auto_mode(1'b0),
        .i_clear(clr),
        .o_fault(o_stall_fault)
    );

    // Read path, registered
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rd_data_reg <= 8'h00;
        end else if (hit_fp) begin
            rd_data_reg <= fault_protect_reg;
        end else if (hit_sc) begin
            rd_data_reg <= stall_control_reg;
        end else if (hit_th) begin
            rd_data_reg <= stall_threshold_reg;
        end else begin
            rd_data_reg <= 8'h00;
        end
    end
    assign o_rd_data = rd_data_reg;
    assign o_locked = locked;
    assign o_stall_threshold_count = stall_threshold_reg;
    assign o_fault_out_n = ~(o_overcurrent_fault | o_overheat_fault | o_open_load_fault
        | (fault_protect_reg[stall_cfg_pkg::TEMP_REPORT_BIT] & i_temp_warning)
        | (stall_control_reg[stall_cfg_pkg::STALL_REPORT_BIT] & o_stall_fault));

    a_lock_blocks_th: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        locked && i_wr_en && hit_th |=> $stable(stall_threshold_reg))
        else $error("locked write changed threshold");
    a_lock_sets: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !locked && wr_fp && i_wr_data[6:4] == 3'h6 |=> locked)
        else $error("lock code did not lock");
    a_unlock_only: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        locked && wr_fp && i_wr_data[6:4] != 3'h3 |=> locked)
        else $error("wrong code unlocked");
    a_unlocked_stays: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        lock_field == 3'h3 && wr_fp && i_wr_data[6:4] != 3'h6 |=> lock_field == 3'h3)
        else $error("lock field changed while unlocked");
    a_clear_pulse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        (wr_fp && i_wr_data[7]) ##1 !(wr_fp && i_wr_data[7]) |-> clr ##1 !clr)
        else $error("fault clear not a pulse");
    a_clear_latched: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        clr && !i_stall_raw |=> !o_stall_fault)
        else $error("stall fault survived clear");
    a_learn_ends: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        $rose(learn_busy) |-> ##[1:64] !learn_busy)
        else $error("stall learn never cleared");
    a_stall_report: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        o_stall_fault && stall_control_reg[3] |-> !o_fault_out_n)
        else $error("stall not reported");
    a_warn_masked: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        i_temp_warning && fault_protect_reg[0] |-> !o_fault_out_n)
        else $error("warning not reported");
    a_stall_off: assert property (@(posedge i_ref_clk) disable iff (i_reset)
        !stall_control_reg[4] && !o_stall_fault |=> !o_stall_fault)
        else $error("stall set while disabled");
endmodule // stall_fault_regs

// ### verification/host_model.sv
`timescale 1ns/1ns
module host_model (
    // Clock
    input wire logic i_ref_clk,
    // Register port
    input wire logic [7:0] i_rd_data,
    output logic o_wr_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data
);
    initial begin
        o_wr_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end
    // Single byte, strobe held for one edge; callers keep reserved bits zero
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_ref_clk);
        #1;
        o_wr_en = 1'b1;
        o_addr = addr;
        o_wr_data = data;
        @(posedge i_ref_clk);
        #1;
        o_wr_en = 1'b0;
        // Inverted leftover data exposes a missing strobe qualifier
        o_wr_data = ~data;
    endtask
    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_ref_clk);
        #1;
        o_addr = addr;
        @(posedge i_ref_clk);
        #1;
        data = i_rd_data;
    endtask
endmodule // host_model

// ### verification/tb_stepper_fault_stall_config_regs.sv
`timescale 1ns/1ns
module tb_stepper_fault_stall_config_regs;
    localparam int LEARN = 16;
    localparam int OL_TAB [4] = '{20, 15, 10, 3};
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic wr_en;
    logic [7:0] addr, wr_data, rd_data, thr;
    logic [1:0] cond = 2'b00;
    logic temp_warning = 1'b0, open_load_raw = 1'b0, stall_raw = 1'b0;
    logic slew_blank_done = 1'b0, stall_learn_done = 1'b0;
    logic fault_out_n, locked, blank_done;
    logic [3:0] flt;
    int n_errors = 0;
    int n_tests = 0;
    always #4 ref_clk = ~ref_clk;
    host_model host_model_i (.i_ref_clk(ref_clk), .i_rd_data(rd_data), .o_wr_en(wr_en),
        .o_addr(addr), .o_wr_data(wr_data));
    stall_fault_regs #(.OL_CYCLES_0(20), .OL_CYCLES_1(15), .OL_CYCLES_2(10), .OL_CYCLES_3(3),
        .LEARN_CYCLES(LEARN)) stall_fault_regs_i (
        .i_ref_clk(ref_clk), .i_reset(reset), .i_wr_en(wr_en), .i_addr(addr),
        .i_wr_data(wr_data), .o_rd_data(rd_data), .i_overcurrent(cond[0]),
        .i_overheat(cond[1]), .i_temp_warning(temp_warning), .i_open_load_raw(open_load_raw),
        .i_stall_raw(stall_raw), .i_slew_blank_done(slew_blank_done),
        .i_stall_learn_done(stall_learn_done), .o_fault_out_n(fault_out_n),
        .o_locked(locked), .o_overcurrent_fault(flt[0]), .o_overheat_fault(flt[1]),
        .o_open_load_fault(flt[2]), .o_stall_fault(flt[3]), .o_blank_done(blank_done),
        .o_stall_threshold_count(thr));
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] got;
        host_model_i.read(a, got);
        check("rd_data", exp, got);
    endtask
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs about 280 cycles; ample margin
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
    initial begin
        step(8);
        reset = 1'b0;
        rd_chk(8'h06, 8'h30);
        rd_chk(8'h07, 8'h08);
        rd_chk(8'h08, 8'h0F);
        rd_chk(8'h20, 8'h00);
        check("fault_out_n", 8'h01, {7'h00, fault_out_n});
        host_model_i.write(8'h08, 8'hFF);
        check("threshold", 8'hFF, thr);
        host_model_i.write(8'h08, 8'h00);
        rd_chk(8'h08, 8'h00);
        host_model_i.write(8'h07, 8'h1F);
        rd_chk(8'h07, 8'h1F);
        host_model_i.write(8'h06, 8'h5F);
        rd_chk(8'h06, 8'h3F);
        host_model_i.write(8'h06, 8'h30);
        host_model_i.write(8'h06, 8'h60);
        check("locked", 8'h01, {7'h00, locked});
        host_model_i.write(8'h08, 8'h55);
        host_model_i.write(8'h07, 8'h08);
        host_model_i.write(8'h06, 8'h5F);
        rd_chk(8'h06, 8'h60);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h07, 8'h1F);
        host_model_i.write(8'h06, 8'h30);
        check("locked", 8'h00, {7'h00, locked});
        host_model_i.write(8'h07, 8'h08);
        for (int k = 0; k < 2; k++) begin
            host_model_i.write(8'h06, 8'h30);
            cond[k] = 1'b1;
            step(3);
            cond[k] = 1'b0;
            step(3);
            check("latched", 8'h01, {7'h00, flt[k]});
            host_model_i.write(8'h06, 8'hB0);
            step(2);
            check("cleared", 8'h00, {7'h00, flt[k]});
            rd_chk(8'h06, 8'h30);
            host_model_i.write(8'h06, 8'h30 | (8'h04 >> k));
            cond[k] = 1'b1;
            step(3);
            check("retry set", 8'h01, {7'h00, flt[k]});
            cond[k] = 1'b0;
            step(3);
            check("retry gone", 8'h00, {7'h00, flt[k]});
        end
        // Fault clear must still act while locked
        host_model_i.write(8'h06, 8'h30);
        cond[1] = 1'b1;
        step(3);
        cond[1] = 1'b0;
        host_model_i.write(8'h06, 8'h60);
        host_model_i.write(8'h06, 8'hE0);
        step(2);
        check("locked clear", 8'h00, {7'h00, flt[1]});
        host_model_i.write(8'h06, 8'h30);
        temp_warning = 1'b1;
        step(2);
        check("warn hidden", 8'h01, {7'h00, fault_out_n});
        host_model_i.write(8'h06, 8'h31);
        check("warn shown", 8'h00, {7'h00, fault_out_n});
        temp_warning = 1'b0;
        host_model_i.write(8'h06, 8'h30);
        stall_raw = 1'b1;
        step(3);
        check("stall off", 8'h00, {7'h00, flt[3]});
        host_model_i.write(8'h07, 8'h18);
        step(3);
        check("stall on", 8'h10, {3'h0, flt[3], 3'h0, fault_out_n});
        stall_raw = 1'b0;
        host_model_i.write(8'h07, 8'h10);
        host_model_i.write(8'h06, 8'hB0);
        stall_raw = 1'b1;
        step(3);
        check("stall quiet", 8'h11, {3'h0, flt[3], 3'h0, fault_out_n});
        stall_raw = 1'b0;
        host_model_i.write(8'h06, 8'hB0);
        open_load_raw = 1'b1;
        step(30);
        check("ol disabled", 8'h00, {7'h00, flt[2]});
        open_load_raw = 1'b0;
        for (int s = 0; s < 4; s++) begin
            host_model_i.write(8'h07, 8'h08 | 8'(s << 1));
            host_model_i.write(8'h06, 8'h38);
            open_load_raw = 1'b1;
            step(OL_TAB[s] - 2);
            check("ol early", 8'h00, {7'h00, flt[2]});
            step(4);
            check("ol window", 8'h01, {7'h00, flt[2]});
            open_load_raw = 1'b0;
            host_model_i.write(8'h06, 8'hB0);
        end
        host_model_i.write(8'h07, 8'h28);
        rd_chk(8'h07, 8'h28);
        stall_learn_done = 1'b1;
        step(1);
        stall_learn_done = 1'b0;
        rd_chk(8'h07, 8'h08);
        host_model_i.write(8'h07, 8'h28);
        step(LEARN - 4);
        rd_chk(8'h07, 8'h28);
        step(6);
        rd_chk(8'h07, 8'h08);
        host_model_i.write(8'h07, 8'h09);
        check("slew blank", 8'h00, {7'h00, blank_done});
        slew_blank_done = 1'b1;
        step(1);
        check("slew blank", 8'h01, {7'h00, blank_done});
        slew_blank_done = 1'b0;
        host_model_i.write(8'h07, 8'h08);
        check("fixed blank", 8'h01, {7'h00, blank_done});
        print_verdict();
    end
endmodule // tb_stepper_fault_stall_config_regs
